// ### cup_pkg.sv
// Constants, field layouts and carrier types of the capacitor current unbalance stage.
// Assumes one 40 MHz core clock and a measurement front end that pulses once per 5 ms pass.
// Overview of operation
// - Eight setting groups are held; the group selector input chooses the active one.
// - Zero delay gives instant operation; nonzero delay gives time-delayed operation.
// - While any phase is saturated, picked-up comparisons are held, not released.
// - Each pass: capture, process, saturation check, compare, block check, delay, outputs.
// - Five flags are output: alarm start, alarm, start, trip and blocked.
// - Every rise and fall of each flag emits a stamped ON or OFF event.
// - Instant start and trip events carry the identical stamp of their pass.
// - Event stamps count whole milliseconds.
// - Each flag has a cumulative rise counter that software can clear.
// - The pre-fault value is the mean max minus min spread of the last twenty milliseconds.
// - Mode codes: 1 on, 2 blocked, 3 test, 4 test blocked, 5 off; reset on.
// - When forcing is permitted, the force code overrides the flags except in off mode; reset normal.
// - Mode and force live outside the setting groups and ignore group changes.
// - Block input and group selector may change at any time during operation.
// - Unbalance is max minus min over max, compared with alarm and trip thresholds.
// - A picked-up comparison releases only below 97 percent of its threshold.
// - Pick-up raises start when unblocked, and blocked instead when blocked.
// - Alarm and trip each have their own delay in 5 ms steps.
`default_nettype none
package cup_pkg;
	// ************************************************************
	// Widths
	// ************************************************************
	localparam int CUR_W = 16;
	localparam int FIELD_W = 16;
	localparam int TS_W = 32;
	localparam int CNT_W = 16;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int WIDE_W = 40;
	localparam int NUM_GROUPS = 8;
	localparam int GRP_W = 3;
	localparam int NUM_FLAGS = 5;
	localparam int CODE_W = 3;
	localparam int MODE_W = 3;
	// ************************************************************
	// Flag positions
	// ************************************************************
	localparam int FLG_ALARM_START = 0;
	localparam int FLG_ALARM = 1;
	localparam int FLG_START = 2;
	localparam int FLG_TRIP = 3;
	localparam int FLG_BLOCKED = 4;
	// ************************************************************
	// Mode and forced status codes
	// ************************************************************
	localparam logic [MODE_W-1:0] MODE_ON = 3'h1;
	localparam logic [MODE_W-1:0] MODE_BLOCKED = 3'h2;
	localparam logic [MODE_W-1:0] MODE_TEST = 3'h3;
	localparam logic [MODE_W-1:0] MODE_TEST_BLOCKED = 3'h4;
	localparam logic [MODE_W-1:0] MODE_OFF = 3'h5;
	localparam logic [MODE_W-1:0] FORCE_NORMAL = 3'h0;
	localparam logic [MODE_W-1:0] FORCE_BLOCKED = 3'h1;
	localparam logic [MODE_W-1:0] FORCE_ALARM_START = 3'h2;
	localparam logic [MODE_W-1:0] FORCE_ALARM = 3'h3;
	localparam logic [MODE_W-1:0] FORCE_TRIP_START = 3'h4;
	localparam logic [MODE_W-1:0] FORCE_TRIP = 3'h5;
	// ************************************************************
	// Ratio arithmetic: thresholds are in hundredths of the reference
	// ************************************************************
	localparam int RATIO_SCALE = 100;
	localparam int PCT_SCALE = 100;
	localparam int RESET_PCT = 97;
	localparam logic [WIDE_W-1:0] LHS_SCALE = WIDE_W'(RATIO_SCALE * PCT_SCALE);
	localparam logic [WIDE_W-1:0] PICK_PCT = WIDE_W'(PCT_SCALE);
	localparam logic [WIDE_W-1:0] REL_PCT = WIDE_W'(RESET_PCT);
	localparam logic [CUR_W-1:0] SAT_LEVEL = 16'hfff0;
	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_HZ = 40_000_000;
	localparam int TS_RES_MS = 1;
	localparam int TS_TICK_CYCLES = CLK_HZ / 1000 * TS_RES_MS;
	localparam int MEAS_BASE_MS = 5;
	localparam int PREFAULT_WIN_MS = 20;
	localparam int PREFAULT_TAPS = PREFAULT_WIN_MS / MEAS_BASE_MS;
	localparam int PREFAULT_SHIFT = $clog2(PREFAULT_TAPS);
	// ************************************************************
	// Register offsets and reset values
	// ************************************************************
	localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h01;
	localparam logic [ADDR_W-1:0] OFS_CNT_CLR = 8'h02;
	localparam logic [ADDR_W-1:0] OFS_TIMESTAMP = 8'h03;
	localparam logic [ADDR_W-1:0] OFS_PREFAULT = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_CNT_BASE = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_SET_BASE = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_SET_END = 8'h40;
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_FORCE_LSB = 4;
	localparam int STAT_SAT_BIT = 5;
	localparam int STAT_MODE_LSB = 8;
	localparam int SET_FIELD_W = 2;
	localparam logic [SET_FIELD_W-1:0] FLD_ALARM_THR = 2'h0;
	localparam logic [SET_FIELD_W-1:0] FLD_TRIP_THR = 2'h1;
	localparam logic [SET_FIELD_W-1:0] FLD_ALARM_DLY = 2'h2;
	localparam logic [SET_FIELD_W-1:0] FLD_TRIP_DLY = 2'h3;
	localparam logic [FIELD_W-1:0] DEF_THR = 16'h0078;
	localparam logic [FIELD_W-1:0] DEF_DLY = 16'h0008;
	// ************************************************************
	// Carrier types
	// ************************************************************
	typedef struct packed {
		logic [CUR_W-1:0] a;
		logic [CUR_W-1:0] b;
		logic [CUR_W-1:0] c;
	} cup_meas_type;
	typedef struct packed {
		logic [FIELD_W-1:0] alarm_thr;
		logic [FIELD_W-1:0] trip_thr;
		logic [FIELD_W-1:0] alarm_dly;
		logic [FIELD_W-1:0] trip_dly;
	} cup_group_type;
	typedef struct packed {
		logic [CODE_W-1:0] code;
		logic on;
		logic [TS_W-1:0] stamp;
	} cup_event_type;
endpackage : cup_pkg
`default_nettype wire

// ### cup_group_mem.sv
// Storage of the eight setting groups, written field by field, read as one registered word.
// Assumes writes come from the register port of the stage and the read group may change any cycle.
`timescale 1ns/1ps
`default_nettype none
module cup_group_mem
(
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_wr_en,
	input wire logic [cup_pkg::GRP_W-1:0] i_wr_group,
	input wire logic [cup_pkg::SET_FIELD_W-1:0] i_wr_field,
	input wire logic [cup_pkg::FIELD_W-1:0] i_wr_data,
	input wire logic [cup_pkg::GRP_W-1:0] i_rd_group,
	output cup_pkg::cup_group_type o_rd_data
);
	import cup_pkg::*;
	cup_group_type mem_reg [NUM_GROUPS];
	cup_group_type mem_next [NUM_GROUPS];
	cup_group_type rd_reg;
	// ************************************************************
	// Entries
	// ************************************************************
	genvar g;
	generate
		for (g = 0; g < NUM_GROUPS; g++)
		begin : g_entry
			always_comb
			begin
				mem_next[g] = mem_reg[g];
				if (i_wr_en && i_wr_group == GRP_W'(g))
				begin
					unique case (i_wr_field)
						FLD_ALARM_THR: mem_next[g].alarm_thr = i_wr_data;
						FLD_TRIP_THR: mem_next[g].trip_thr = i_wr_data;
						FLD_ALARM_DLY: mem_next[g].alarm_dly = i_wr_data;
						FLD_TRIP_DLY: mem_next[g].trip_dly = i_wr_data;
					endcase
				end
			end
			always_ff @(posedge i_core_clk or negedge i_rst_n)
			begin
				if (!i_rst_n)
					mem_reg[g] <= '{DEF_THR, DEF_THR, DEF_DLY, DEF_DLY};
				else
					mem_reg[g] <= mem_next[g];
			end
		end
	endgenerate
	// Registered read keeps the wide ratio arithmetic off the selector path.
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			rd_reg <= '{DEF_THR, DEF_THR, DEF_DLY, DEF_DLY};
		else
			rd_reg <= mem_reg[i_rd_group];
	end
	assign o_rd_data = rd_reg;
endmodule : cup_group_mem
`default_nettype wire

// ### cup_unbalance_stage.sv
// Current unbalance protection stage: ratio compare, delays, flags, events and counters.
// Assumes i_meas_valid pulses once per measurement pass, no faster than every dozen cycles.
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module cup_unbalance_stage
#(
	parameter int TS_TICK = cup_pkg::TS_TICK_CYCLES
)
(
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire cup_pkg::cup_meas_type i_meas,
	input wire logic i_meas_valid,
	input wire logic [cup_pkg::GRP_W-1:0] i_group_sel,
	input wire logic i_block,
	input wire logic i_force_enable,
	input wire logic [cup_pkg::ADDR_W-1:0] i_addr,
	input wire logic [cup_pkg::DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [cup_pkg::DATA_W-1:0] o_rdata,
	output logic [cup_pkg::NUM_FLAGS-1:0] o_flags,
	output logic o_evt_valid,
	output cup_pkg::cup_event_type o_evt,
	output logic [cup_pkg::CUR_W-1:0] o_prefault_avg,
	output logic o_saturated
);
	import cup_pkg::*;
	localparam logic [CNT_W-1:0] CNT_MAX = '1;
	// ************************************************************
	// Control register and settings access
	// ************************************************************
	logic [MODE_W-1:0] mode_reg, mode_next, force_reg, force_next;
	logic [NUM_FLAGS-1:0] cnt_clr;
	logic set_wr;
	logic [ADDR_W-1:0] set_idx;
	cup_group_type grp;
	logic [MODE_W-1:0] wmode, wforce;
	assign wmode = i_wdata[CTRL_MODE_LSB +: MODE_W];
	assign wforce = i_wdata[CTRL_FORCE_LSB +: MODE_W];
	assign set_wr = i_wr && i_addr >= OFS_SET_BASE && i_addr < OFS_SET_END;
	assign set_idx = i_addr - OFS_SET_BASE;
	assign cnt_clr = (i_wr && i_addr == OFS_CNT_CLR) ? i_wdata[NUM_FLAGS-1:0] : '0;
	always_comb
	begin
		mode_next = mode_reg;
		force_next = force_reg;
		if (i_wr && i_addr == OFS_CTRL)
		begin
			// Illegal codes are ignored so the stage never sits in an undefined mode.
			if (wmode >= MODE_ON && wmode <= MODE_OFF)
				mode_next = wmode;
			if (wforce <= FORCE_TRIP)
				force_next = wforce;
		end
	end
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			mode_reg <= MODE_ON;
			force_reg <= FORCE_NORMAL;
		end
		else
		begin
			mode_reg <= mode_next;
			force_reg <= force_next;
		end
	end
	cup_group_mem u_group_mem
	(
		.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n),
		.i_wr_en(set_wr),
		.i_wr_group(set_idx[SET_FIELD_W +: GRP_W]),
		.i_wr_field(set_idx[SET_FIELD_W-1:0]),
		.i_wr_data(i_wdata[FIELD_W-1:0]),
		.i_rd_group(i_group_sel),
		.o_rd_data(grp)
	);
	// ************************************************************
	// Millisecond time base
	// ************************************************************
	logic [CNT_W-1:0] tick_reg, tick_next;
	logic [TS_W-1:0] ts_reg, ts_next;
	logic ms_tick;
	assign ms_tick = tick_reg == CNT_W'(TS_TICK - 1);
	always_comb
	begin
		tick_next = ms_tick ? '0 : tick_reg + 1'b1;
		ts_next = ms_tick ? ts_reg + 1'b1 : ts_reg;
	end
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			tick_reg <= '0;
			ts_reg <= '0;
		end
		else
		begin
			tick_reg <= tick_next;
			ts_reg <= ts_next;
		end
	end
	// ************************************************************
	// Processing pass
	// ************************************************************
	cup_meas_type meas_reg, meas_next;
	logic upd_reg, upd_next;
	logic ap_reg, ap_next, tp_reg, tp_next;
	logic [FIELD_W-1:0] acnt_reg, acnt_next, tcnt_reg, tcnt_next;
	logic [NUM_FLAGS-1:0] flags_reg, flags_next, rise, fall;
	logic [CUR_W-1:0] hist_reg [PREFAULT_TAPS];
	logic [CUR_W-1:0] hist_next [PREFAULT_TAPS];
	logic [CUR_W-1:0] avg_reg, avg_next;
	logic [CUR_W-1:0] cmax, cmin, diff;
	logic [WIDE_W-1:0] lhs, a_pick, a_rel, t_pick, t_rel;
	logic [CUR_W+PREFAULT_SHIFT-1:0] hsum;
	logic sat, blk, forced, a_start, t_start;
	always_comb
	begin
		meas_next = i_meas_valid ? i_meas : meas_reg;
		upd_next = i_meas_valid;
		// Input processing: extremes and spread of the three phases.
		cmax = meas_reg.a;
		cmin = meas_reg.a;
		if (meas_reg.b > cmax) cmax = meas_reg.b;
		if (meas_reg.c > cmax) cmax = meas_reg.c;
		if (meas_reg.b < cmin) cmin = meas_reg.b;
		if (meas_reg.c < cmin) cmin = meas_reg.c;
		diff = cmax - cmin;
		// Cross multiplied to avoid a divider: diff/max >= thr/100.
		lhs = WIDE_W'(diff) * LHS_SCALE;
		a_pick = WIDE_W'(grp.alarm_thr) * WIDE_W'(cmax) * PICK_PCT;
		a_rel = WIDE_W'(grp.alarm_thr) * WIDE_W'(cmax) * REL_PCT;
		t_pick = WIDE_W'(grp.trip_thr) * WIDE_W'(cmax) * PICK_PCT;
		t_rel = WIDE_W'(grp.trip_thr) * WIDE_W'(cmax) * REL_PCT;
		sat = (meas_reg.a >= SAT_LEVEL) || (meas_reg.b >= SAT_LEVEL) || (meas_reg.c >= SAT_LEVEL);
		blk = i_block || mode_reg == MODE_BLOCKED || mode_reg == MODE_TEST_BLOCKED;
		forced = i_force_enable && force_reg != FORCE_NORMAL;
		ap_next = ap_reg;
		tp_next = tp_reg;
		if (!sat)
		begin
			ap_next = ap_reg ? (lhs >= a_rel) : (lhs >= a_pick);
			tp_next = tp_reg ? (lhs >= t_rel) : (lhs >= t_pick);
		end
		a_start = ap_next && !blk;
		t_start = tp_next && !blk;
		flags_next = '0;
		flags_next[FLG_ALARM_START] = a_start;
		flags_next[FLG_ALARM] = a_start && acnt_reg >= grp.alarm_dly;
		flags_next[FLG_START] = t_start;
		flags_next[FLG_TRIP] = t_start && tcnt_reg >= grp.trip_dly;
		flags_next[FLG_BLOCKED] = (ap_next || tp_next) && blk;
		acnt_next = (a_start && !flags_next[FLG_ALARM]) ? acnt_reg + 1'b1 : (a_start ? acnt_reg : '0);
		tcnt_next = (t_start && !flags_next[FLG_TRIP]) ? tcnt_reg + 1'b1 : (t_start ? tcnt_reg : '0);
		if (forced)
		begin
			flags_next = '0;
			unique case (force_reg)
				FORCE_BLOCKED: flags_next[FLG_BLOCKED] = 1'b1;
				FORCE_ALARM_START: flags_next[FLG_ALARM_START] = 1'b1;
				FORCE_ALARM: flags_next[FLG_ALARM_START +: 2] = 2'h3;
				FORCE_TRIP_START: flags_next[FLG_START] = 1'b1;
				FORCE_TRIP: flags_next[FLG_START +: 2] = 2'h3;
				default: flags_next = '0;
			endcase
		end
		if (mode_reg == MODE_OFF)
		begin
			flags_next = '0;
			ap_next = 1'b0;
			tp_next = 1'b0;
			acnt_next = '0;
			tcnt_next = '0;
		end
		hsum = '0;
		for (int i = 0; i < PREFAULT_TAPS; i++)
		begin
			hist_next[i] = hist_reg[i];
			hsum = hsum + (CUR_W+PREFAULT_SHIFT)'(hist_reg[i]);
		end
		avg_next = hsum[PREFAULT_SHIFT +: CUR_W];
		if (upd_reg)
		begin
			hist_next[0] = diff;
			for (int i = 1; i < PREFAULT_TAPS; i++)
				hist_next[i] = hist_reg[i-1];
		end
		else
		begin
			ap_next = ap_reg;
			tp_next = tp_reg;
			acnt_next = acnt_reg;
			tcnt_next = tcnt_reg;
			flags_next = flags_reg;
		end
		rise = flags_next & ~flags_reg;
		fall = ~flags_next & flags_reg;
	end
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			meas_reg <= '0;
			upd_reg <= 1'b0;
			ap_reg <= 1'b0;
			tp_reg <= 1'b0;
			acnt_reg <= '0;
			tcnt_reg <= '0;
			flags_reg <= '0;
			avg_reg <= '0;
			for (int i = 0; i < PREFAULT_TAPS; i++)
				hist_reg[i] <= '0;
		end
		else
		begin
			meas_reg <= meas_next;
			upd_reg <= upd_next;
			ap_reg <= ap_next;
			tp_reg <= tp_next;
			acnt_reg <= acnt_next;
			tcnt_reg <= tcnt_next;
			flags_reg <= flags_next;
			avg_reg <= avg_next;
			for (int i = 0; i < PREFAULT_TAPS; i++)
				hist_reg[i] <= hist_next[i];
		end
	end
	assign o_flags = flags_reg;
	assign o_saturated = sat;
	assign o_prefault_avg = avg_reg;
	// ************************************************************
	// Event serialiser
	// ************************************************************
	// Events of one pass leave one per cycle, all with the stamp captured at that pass.
	logic [NUM_FLAGS-1:0] pon_reg, pon_next, poff_reg, poff_next;
	logic [TS_W-1:0] stamp_reg, stamp_next;
	cup_event_type evt_reg, evt_next;
	logic evt_valid_reg, evt_valid_next, found;
	always_comb
	begin
		pon_next = pon_reg;
		poff_next = poff_reg;
		evt_next = evt_reg;
		found = 1'b0;
		for (int i = 0; i < NUM_FLAGS; i++)
		begin
			if (!found && pon_reg[i])
			begin
				found = 1'b1;
				pon_next[i] = 1'b0;
				evt_next.code = CODE_W'(i);
				evt_next.on = 1'b1;
			end
		end
		for (int i = 0; i < NUM_FLAGS; i++)
		begin
			if (!found && poff_reg[i])
			begin
				found = 1'b1;
				poff_next[i] = 1'b0;
				evt_next.code = CODE_W'(i);
				evt_next.on = 1'b0;
			end
		end
		evt_next.stamp = stamp_reg;
		evt_valid_next = found;
		// New changes are merged after the drain so none is lost.
		pon_next = pon_next | rise;
		poff_next = poff_next | fall;
		stamp_next = upd_reg ? ts_reg : stamp_reg;
	end
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			pon_reg <= '0;
			poff_reg <= '0;
			stamp_reg <= '0;
			evt_reg <= '0;
			evt_valid_reg <= 1'b0;
		end
		else
		begin
			pon_reg <= pon_next;
			poff_reg <= poff_next;
			stamp_reg <= stamp_next;
			evt_reg <= evt_next;
			evt_valid_reg <= evt_valid_next;
		end
	end
	assign o_evt = evt_reg;
	assign o_evt_valid = evt_valid_reg;
	// ************************************************************
	// Cumulative counters
	// ************************************************************
	logic [CNT_W-1:0] cnt_reg [NUM_FLAGS];
	logic [CNT_W-1:0] cnt_next [NUM_FLAGS];
	genvar f;
	generate
		for (f = 0; f < NUM_FLAGS; f++)
		begin : g_cnt
			always_comb
			begin
				cnt_next[f] = cnt_clr[f] ? '0 : cnt_reg[f];
				if (rise[f])
					cnt_next[f] = cnt_clr[f] ? CNT_W'(1) : (cnt_reg[f] == CNT_MAX ? CNT_MAX : cnt_reg[f] + 1'b1);
			end
			always_ff @(posedge i_core_clk or negedge i_rst_n)
			begin
				if (!i_rst_n)
					cnt_reg[f] <= '0;
				else
					cnt_reg[f] <= cnt_next[f];
			end
			property p_cnt_inc;
				@(posedge i_core_clk) disable iff (!i_rst_n)
				(rise[f] && !cnt_clr[f] && cnt_reg[f] != CNT_MAX) |=> cnt_reg[f] == $past(cnt_reg[f]) + 1'b1;
			endproperty
			a_cnt_inc: assert property (p_cnt_inc) else $error("counter missed an event");
			property p_cnt_sat;
				@(posedge i_core_clk) disable iff (!i_rst_n)
				(cnt_reg[f] == CNT_MAX && !cnt_clr[f]) |=> cnt_reg[f] == CNT_MAX;
			endproperty
			a_cnt_sat: assert property (p_cnt_sat) else $error("counter wrapped");
		end
	endgenerate
	// ************************************************************
	// Read port
	// ************************************************************
	logic [DATA_W-1:0] rdata_reg, rdata_next;
	logic [ADDR_W-1:0] cnt_idx;
	assign cnt_idx = i_addr - OFS_CNT_BASE;
	always_comb
	begin
		rdata_next = '0;
		if (i_rd)
		begin
			if (i_addr == OFS_CTRL)
			begin
				rdata_next[CTRL_MODE_LSB +: MODE_W] = mode_reg;
				rdata_next[CTRL_FORCE_LSB +: MODE_W] = force_reg;
			end
			else if (i_addr == OFS_STATUS)
			begin
				rdata_next[NUM_FLAGS-1:0] = flags_reg;
				rdata_next[STAT_SAT_BIT] = sat;
				rdata_next[STAT_MODE_LSB +: MODE_W] = mode_reg;
			end
			else if (i_addr == OFS_TIMESTAMP)
				rdata_next = ts_reg;
			else if (i_addr == OFS_PREFAULT)
				rdata_next[CUR_W-1:0] = avg_reg;
			else if (i_addr >= OFS_CNT_BASE && cnt_idx < ADDR_W'(NUM_FLAGS))
				rdata_next[CNT_W-1:0] = cnt_reg[cnt_idx[CODE_W-1:0]];
		end
	end
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			rdata_reg <= '0;
		else
			rdata_reg <= rdata_next;
	end
	assign o_rdata = rdata_reg;
	// ************************************************************
	// Checks
	// ************************************************************
	property p_off;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(upd_reg && mode_reg == MODE_OFF) |=> flags_reg == '0;
	endproperty
	a_off: assert property (p_off) else $error("flags active in off mode");
	property p_blocked;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(upd_reg && blk && !forced && mode_reg != MODE_OFF && (ap_next || tp_next))
			|=> flags_reg[FLG_BLOCKED] && !flags_reg[FLG_START] && !flags_reg[FLG_ALARM_START];
	endproperty
	a_blocked: assert property (p_blocked) else $error("blocked pick-up gave start");
	property p_hold;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(upd_reg && ap_reg && !sat && mode_reg != MODE_OFF && lhs >= a_rel) |=> ap_reg;
	endproperty
	a_hold: assert property (p_hold) else $error("released above reset ratio");
	property p_sat_hold;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(upd_reg && sat && mode_reg != MODE_OFF) |=> (ap_reg == $past(ap_reg)) && (tp_reg == $past(tp_reg));
	endproperty
	a_sat_hold: assert property (p_sat_hold) else $error("pick-up changed while saturated");
	property p_delay;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(upd_reg && !forced && acnt_reg < grp.alarm_dly) |=> !flags_reg[FLG_ALARM];
	endproperty
	a_delay: assert property (p_delay) else $error("alarm before its delay");
	property p_instant;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(upd_reg && !forced && mode_reg != MODE_OFF && t_start && grp.trip_dly == '0)
			|=> flags_reg[FLG_START] && flags_reg[FLG_TRIP];
	endproperty
	a_instant: assert property (p_instant) else $error("instant trip not raised with start");
	property p_evt_out;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(rise != '0 || fall != '0) |-> ##[1:12] (o_evt_valid && o_evt.stamp == stamp_reg);
	endproperty
	a_evt_out: assert property (p_evt_out) else $error("flag change gave no event");
	property p_same_stamp;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(rise[FLG_START] && rise[FLG_TRIP])
			|=> ##[1:3] (o_evt_valid && o_evt.on && o_evt.code == CODE_W'(FLG_START))
			##1 (o_evt_valid && o_evt.on && o_evt.code == CODE_W'(FLG_TRIP) && o_evt.stamp == $past(o_evt.stamp));
	endproperty
	a_same_stamp: assert property (p_same_stamp) else $error("trip stamp differs from start");
	property p_ms;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		ms_tick |=> ts_reg == $past(ts_reg) + 1'b1 ##1 !ms_tick;
	endproperty
	a_ms: assert property (p_ms) else $error("timestamp not counting milliseconds");
endmodule : cup_unbalance_stage
`default_nettype wire

// ### cup_meas_src.sv
// Front end model: one pass of three phase RMS currents per request.
// Assumes the bench spaces requests at least 15 core cycles apart.
`timescale 1ns/1ps
`default_nettype none
module cup_meas_src
(
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_go,
	input wire cup_pkg::cup_meas_type i_cur,
	output var cup_pkg::cup_meas_type o_meas,
	output logic o_meas_valid
);
	import cup_pkg::*;
	// ********
	// Pass output
	// ********
	cup_meas_type meas_next;
	logic vld_next;
	// Between passes the lines toggle, so a late capture cannot look right.
	always_comb
	begin
		vld_next = i_go;
		meas_next = i_go ? i_cur : ~o_meas;
	end
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_meas <= '0;
			o_meas_valid <= 1'b0;
		end
		else
		begin
			o_meas <= meas_next;
			o_meas_valid <= vld_next;
		end
	end
endmodule : cup_meas_src
`default_nettype wire

// ### tb_top.sv
// Self-checking bench of the unbalance stage through its register port and passes.
// Assumes TS_TICK of 4, so a millisecond is four core cycles.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import cup_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic go = 1'b0;
	logic blk = 1'b0;
	logic fen = 1'b0;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic [2:0] grp = 3'h0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	cup_meas_type cur = '0;
	cup_meas_type meas;
	logic vld;
	logic [31:0] rdata;
	logic [4:0] flags;
	logic evt_v;
	logic sat_o;
	logic [15:0] pfa;
	cup_event_type evt;
	logic [31:0] st [5] = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h0};
	int num_errors = 0;
	int num_checks = 0;
	always #12.5 clk = ~clk;
	cup_meas_src src_u (.i_core_clk(clk), .i_rst_n(rst_n), .i_go(go), .i_cur(cur), .o_meas(meas),
		.o_meas_valid(vld));
	cup_unbalance_stage #(.TS_TICK(4)) dut_u (.i_core_clk(clk), .i_rst_n(rst_n), .i_meas(meas),
		.i_meas_valid(vld), .i_group_sel(grp), .i_block(blk), .i_force_enable(fen), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .o_flags(flags), .o_evt_valid(evt_v),
		.o_evt(evt), .o_prefault_avg(pfa), .o_saturated(sat_o));
	// ON stamps are kept per flag so that simultaneous events can be compared later.
	always @(posedge clk)
		if (evt_v === 1'b1 && evt.on === 1'b1)
			st[evt.code] <= evt.stamp;
	task automatic end_sim;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_sim
	task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[ERR] %s exp %h got %h", what, exp, got);
		end
	endtask : chk_val
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask : wr
	task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1;
		chk_val($sformatf("reg %h", a), exp, rdata);
		@(posedge clk);
	endtask : chk_reg
	task automatic pass(input logic [4:0] exp);
		@(posedge clk);
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		repeat (14) @(posedge clk);
		#1;
		chk_val("flags", {27'h0, exp}, {27'h0, flags});
		@(posedge clk);
	endtask : pass
	initial
	begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		chk_reg(OFS_CTRL, 32'h1);
		wr(OFS_CTRL, 32'h6);
		chk_reg(OFS_CTRL, 32'h1);
		wr(OFS_CTRL, 32'h5);
		chk_reg(OFS_STATUS, 32'h500);
		wr(OFS_CTRL, 32'h1);
		wr(8'h24, 32'd50);
		wr(8'h25, 32'd50);
		wr(8'h26, 32'h1);
		wr(8'h27, 32'h0);
		grp <= 3'h1;
		cur <= '{16'd100, 16'd100, 16'd51};
		pass(5'h00);
		cur.c <= 16'd40;
		pass(5'h0d);
		chk_val("stamp", st[FLG_START], st[FLG_TRIP]);
		cur.c <= 16'd51;
		pass(5'h0f);
		cur <= '{16'hffff, 16'hffff, 16'hffff};
		pass(5'h0f);
		chk_val("sat", 32'h1, {31'h0, sat_o});
		chk_reg(OFS_STATUS, 32'h12f);
		cur <= '{16'd100, 16'd100, 16'd52};
		pass(5'h00);
		cur.c <= 16'd40;
		blk <= 1'b1;
		pass(5'h10);
		chk_val("prefault", 32'd39, {16'h0, pfa});
		chk_reg(OFS_CNT_BASE + 8'h3, 32'h1);
		chk_reg(OFS_CNT_BASE + 8'h4, 32'h1);
		wr(OFS_CNT_CLR, 32'h1f);
		chk_reg(OFS_CNT_BASE + 8'h3, 32'h0);
		blk <= 1'b0;
		grp <= 3'h0;
		pass(5'h00);
		grp <= 3'h1;
		wr(OFS_CTRL, 32'h2);
		pass(5'h10);
		wr(OFS_CTRL, 32'h3);
		pass(5'h0d);
		wr(OFS_CTRL, 32'h4);
		pass(5'h10);
		fen <= 1'b1;
		wr(OFS_CTRL, 32'h51);
		pass(5'h0c);
		wr(OFS_CTRL, 32'h55);
		pass(5'h00);
		grp <= 3'h0;
		chk_reg(OFS_CTRL, 32'h55);
		end_sim();
	end
	initial
	begin
		#20000;
		num_errors++;
		end_sim();
	end
endmodule : tb_top
`default_nettype wire
